// >>> rtl/key_data_mem.sv
// Byte store for the received key data, registered read port
`timescale 1ns/1ps
module key_data_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 84,
	parameter int AW = 7
) (
	input wire logic core_clk_in,
	input wire logic ce_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic [WIDTH-1:0] rd_data_out
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge core_clk_in) begin
		if (ce_in) begin
			if (wr_en_in) begin
				mem_q[wr_addr_in] <= wr_data_in;
			end
			rd_data_out <= mem_q[rd_addr_in];
		end
	end
endmodule : key_data_mem

// >>> rtl/key_set_cmd.sv
// Key setting command interpreter: command framing, checks, key data, status packets
`timescale 1ns/1ps
//
// Overview of operation
// [RULE1] Success status: 81,00,0A,28,00, all-ones details and address, sum D6, 03.
// [RULE2] Failure status: 81,00,0A,A8, status code, details, address, sum, 03.
// [RULE3] A command packet starts at byte 01h; all other bytes are ignored.
// [RULE4] Missing end byte in a command packet gives a packet error.
// [RULE5] Command checksum mismatch gives a checksum error.
// [RULE6] Length wrong for the format or for the command gives a packet error.
// [RULE7] Any framing, acceptance or data error aborts; nothing is written.
// [RULE8] Forbidden lifecycle state or pending encrypted write gives acceptance error.
// [RULE9] Undefined key type gives a parameter error.
// [RULE10] Key type not allowed at current level gives a secure error.
// [RULE11] Level 2 allows all three key types; level 1 only the level-one key.
// [RULE12] OK status is sent before the key data packet is accepted.
// [RULE13] A data packet starts at byte 81h; other bytes are discarded.
// [RULE14] Data packet: bad end byte or length is packet error, bad sum checksum.
// [RULE15] Wrong response byte in the data packet gives a packet error.
// [RULE16] More data than the command specifies gives a parameter error.
// [RULE17] Trusted subsystem abnormal after wrapping: no response at all.
// [RULE18] Wrapping failure gives a trusted-system error.
// [RULE19] Flash write failure gives flash access error carrying flash status.
// [RULE20] Successful key write is answered with OK.
// [RULE21] Highest-priority error is reported; unused fields read all-ones.
// [RULE22] User-key command: length 06h, code 2Ah, address MSB first, then key type.
// [RULE23] Key setting command: length 02h, code 28h, one key-type byte 01h..03h.
// [RULE24] Key data packet: length 0055h, response 28h, 84 bytes of key material.
// [RULE25] Checksum is two's complement of the sum from length high through data.
module key_set_cmd
	import key_set_pkg::*;
#(
	parameter int MEM_AW = 7
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_valid_in,
	output logic [7:0] tx_data_out,
	output logic tx_valid_out,
	input wire logic tx_ready_in,
	input wire logic lifecycle_forbid_in,
	input wire logic enc_write_pending_in,
	input wire logic [1:0] auth_level_in,
	output logic [7:0] key_type_byte_out,
	output logic wrap_start_out,
	input wire logic wrap_done_in,
	input wire logic wrap_fail_in,
	input wire logic trusted_abnormal_in,
	output logic flash_start_out,
	input wire logic flash_done_in,
	input wire logic flash_error_in,
	input wire logic [31:0] flash_status_in,
	input wire logic [MEM_AW-1:0] key_rd_addr_in,
	output logic [7:0] key_rd_data_out,
	output logic [31:0] key_store_address_out,
	output logic [7:0] user_key_type_out,
	output logic user_key_cmd_out
);
	typedef struct packed {
		st_e state;
		st_e ret;
		logic [15:0] cnt;
		logic [15:0] len;
		logic [7:0] acc;
		logic [7:0] cmd;
		logic [39:0] par;
		logic res_bad;
		logic [3:0] idx;
		logic [7:0] res;
		logic [7:0] sts;
		logic [31:0] st2;
		logic [7:0] tx_data;
		logic tx_valid;
		logic [7:0] key_type;
		logic wrap_start;
		logic flash_start;
		logic [31:0] key_addr;
		logic [7:0] ukey_type;
		logic ukey_cmd;
	} state_s;

	state_s st_q;
	state_s st_d;
	logic mem_we;

	////////////////////////////////////////////////////////////////////////////////
	// Status packet builder

	function automatic logic [7:0] status_raw(input logic [3:0] i, input logic [7:0] r,
			input logic [7:0] s, input logic [31:0] d);
		case (i)
			4'h0: status_raw = DATA_START_BYTE;
			4'h1: status_raw = STATUS_LEN[15:8];
			4'h2: status_raw = STATUS_LEN[7:0];
			4'h3: status_raw = r;
			4'h4: status_raw = s;
			4'h5: status_raw = d[31:24];
			4'h6: status_raw = d[23:16];
			4'h7: status_raw = d[15:8];
			4'h8: status_raw = d[7:0];
			4'h9, 4'ha, 4'hb, 4'hc: status_raw = 8'hff;
			4'he: status_raw = END_BYTE;
			default: status_raw = 8'h00;
		endcase
	endfunction : status_raw

	function automatic logic [7:0] status_byte(input logic [3:0] i, input logic [7:0] r,
			input logic [7:0] s, input logic [31:0] d);
		logic [7:0] sum;
		sum = 8'h00;
		if (i == STATUS_SUM_IDX) begin
			for (int k = 1; k < 13; k++) begin
				sum = sum + status_raw(4'(k), r, s, d); // [RULE25]
			end
			status_byte = 8'(-sum);
		end else begin
			status_byte = status_raw(i, r, s, d);
		end
	endfunction : status_byte

	// Payload bytes to collect: a length the format cannot hold is taken as the command
	// byte alone, so the sum and end bytes still line up where a sane host put them
	function automatic logic [15:0] cmd_pay_len(input logic [15:0] l);
		if (l == 16'h0000 || l > CMD_MAX_LEN) begin
			cmd_pay_len = 16'h0001;
		end else begin
			cmd_pay_len = l;
		end
	endfunction : cmd_pay_len

	function automatic logic key_allowed(input logic [1:0] lvl, input logic [7:0] kt);
		key_allowed = (lvl == AUTH_LEVEL_TWO) || (lvl == AUTH_LEVEL_ONE && kt == KEY_LEVEL_ONE);
	endfunction : key_allowed

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb begin
		logic go;
		logic [7:0] snd_sts;
		logic [31:0] snd_st2;
		st_e snd_ret;
		logic [7:0] b;
		go = 1'b0;
		snd_sts = STS_OK;
		snd_st2 = UNUSED_WORD;
		snd_ret = ST_IDLE;
		b = rx_data_in;
		st_d = st_q;
		st_d.wrap_start = 1'b0;
		st_d.flash_start = 1'b0;
		st_d.ukey_cmd = 1'b0;
		mem_we = 1'b0;
		case (st_q.state)
			ST_IDLE: begin
				if (rx_valid_in && b == CMD_START_BYTE) begin // [RULE3]
					st_d.state = ST_CLEN_H;
					st_d.acc = 8'h00;
				end
			end
			ST_CLEN_H: begin
				if (rx_valid_in) begin
					st_d.len[15:8] = b;
					st_d.acc = st_q.acc + b;
					st_d.state = ST_CLEN_L;
				end
			end
			ST_CLEN_L: begin
				if (rx_valid_in) begin
					st_d.len[7:0] = b;
					st_d.acc = st_q.acc + b;
					st_d.cnt = 16'h0000;
					st_d.par = 40'h0;
					st_d.state = ST_CPAY;
				end
			end
			ST_CPAY: begin
				if (rx_valid_in) begin
					st_d.acc = st_q.acc + b;
					if (st_q.cnt == 16'h0000) begin
						st_d.cmd = b;
					end else begin
						st_d.par = {st_q.par[31:0], b}; // [RULE22] Address arrives MSB first
					end
					st_d.cnt = st_q.cnt + 16'h0001;
					if (st_q.cnt + 16'h0001 == cmd_pay_len(st_q.len)) begin
						st_d.state = ST_CSUM;
					end
				end
			end
			ST_CSUM: begin
				if (rx_valid_in) begin
					st_d.acc = st_q.acc + b;
					st_d.state = ST_CETX;
				end
			end
			ST_CETX: begin
				if (rx_valid_in) begin
					// Priority chain, most important first [RULE21]
					st_d.state = ST_IDLE; // [RULE7]
					if (st_q.cmd != CMD_KEY_SET && st_q.cmd != CMD_USER_KEY_SET) begin
						st_d.state = ST_IDLE;
					end else if (b != END_BYTE) begin // [RULE4]
						go = 1'b1;
						snd_sts = STS_PACKET_ERR;
					end else if (st_q.acc != 8'h00) begin // [RULE5] [RULE25]
						go = 1'b1;
						snd_sts = STS_CHECKSUM_ERR;
					end else if (cmd_pay_len(st_q.len) != st_q.len) begin // [RULE6]
						go = 1'b1;
						snd_sts = STS_PACKET_ERR;
					end else if ((st_q.cmd == CMD_KEY_SET && st_q.len != KEY_SET_LEN) ||
							(st_q.cmd == CMD_USER_KEY_SET && st_q.len != USER_KEY_SET_LEN)) begin
						go = 1'b1; // [RULE6] [RULE22] [RULE23]
						snd_sts = STS_PACKET_ERR;
					end else if (st_q.cmd == CMD_USER_KEY_SET) begin
						st_d.key_addr = st_q.par[39:8]; // [RULE22]
						st_d.ukey_type = st_q.par[7:0];
						st_d.ukey_cmd = 1'b1;
					end else if (lifecycle_forbid_in || enc_write_pending_in) begin // [RULE8]
						go = 1'b1;
						snd_sts = STS_ACCEPT_ERR;
					end else if (st_q.par[7:0] < KEY_LEVEL_TWO || st_q.par[7:0] > KEY_RETURN) begin
						go = 1'b1; // [RULE9] [RULE23]
						snd_sts = STS_PARAM_ERR;
					end else if (!key_allowed(auth_level_in, st_q.par[7:0])) begin // [RULE10] [RULE11]
						go = 1'b1;
						snd_sts = STS_SECURE_ERR;
					end else begin
						st_d.key_type = st_q.par[7:0];
						go = 1'b1; // [RULE12]
						snd_sts = STS_OK;
						snd_ret = ST_DWAIT;
					end
				end
			end
			ST_SEND: begin
				if (!st_q.tx_valid || tx_ready_in) begin
					if (st_q.idx == STATUS_BYTES) begin
						st_d.tx_valid = 1'b0;
						st_d.state = st_q.ret;
					end else begin
						st_d.tx_data = status_byte(st_q.idx, st_q.res, st_q.sts, st_q.st2);
						st_d.tx_valid = 1'b1; // [RULE1] [RULE2]
						st_d.idx = st_q.idx + 4'h1;
					end
				end
			end
			ST_DWAIT: begin
				if (rx_valid_in && b == DATA_START_BYTE) begin // [RULE13]
					st_d.state = ST_DLEN_H;
					st_d.acc = 8'h00;
				end
			end
			ST_DLEN_H: begin
				if (rx_valid_in) begin
					st_d.len[15:8] = b;
					st_d.acc = st_q.acc + b;
					st_d.state = ST_DLEN_L;
				end
			end
			ST_DLEN_L: begin
				if (rx_valid_in) begin
					st_d.len[7:0] = b;
					st_d.acc = st_q.acc + b;
					st_d.res_bad = 1'b1;
					st_d.state = ({st_q.len[15:8], b} == 16'h0000) ? ST_DSUM : ST_DRES;
				end
			end
			ST_DRES: begin
				if (rx_valid_in) begin
					st_d.acc = st_q.acc + b;
					st_d.res_bad = (b != RESP_OK); // [RULE15]
					st_d.cnt = 16'h0000;
					st_d.state = (st_q.len == 16'h0001) ? ST_DSUM : ST_DPAY;
				end
			end
			ST_DPAY: begin
				if (rx_valid_in) begin
					st_d.acc = st_q.acc + b;
					// Bytes past the buffer only feed the sum; the length check rejects them
					mem_we = (st_q.cnt < 16'(KEY_DATA_BYTES)); // [RULE24]
					st_d.cnt = st_q.cnt + 16'h0001;
					if (st_q.cnt + 16'h0002 == st_q.len) begin
						st_d.state = ST_DSUM;
					end
				end
			end
			ST_DSUM: begin
				if (rx_valid_in) begin
					st_d.acc = st_q.acc + b;
					st_d.state = ST_DETX;
				end
			end
			ST_DETX: begin
				if (rx_valid_in) begin
					st_d.state = ST_IDLE; // [RULE7]
					go = 1'b1;
					if (b != END_BYTE) begin // [RULE14]
						snd_sts = STS_PACKET_ERR;
					end else if (st_q.acc != 8'h00) begin // [RULE14] [RULE25]
						snd_sts = STS_CHECKSUM_ERR;
					end else if (st_q.len < KEY_DATA_LEN) begin // [RULE14]
						snd_sts = STS_PACKET_ERR;
					end else if (st_q.res_bad) begin // [RULE15]
						snd_sts = STS_PACKET_ERR;
					end else if (st_q.len > KEY_DATA_LEN) begin // [RULE16]
						snd_sts = STS_PARAM_ERR;
					end else begin
						go = 1'b0;
						st_d.wrap_start = 1'b1;
						st_d.state = ST_WRAP;
					end
				end
			end
			ST_WRAP: begin
				if (trusted_abnormal_in) begin // [RULE17]
					st_d.state = ST_HALT;
				end else if (wrap_done_in) begin
					if (wrap_fail_in) begin // [RULE18]
						go = 1'b1;
						snd_sts = STS_TRUSTED_ERR;
					end else begin
						st_d.flash_start = 1'b1;
						st_d.state = ST_FLASH;
					end
				end
			end
			ST_FLASH: begin
				if (trusted_abnormal_in) begin // [RULE17]
					st_d.state = ST_HALT;
				end else if (flash_done_in) begin
					go = 1'b1;
					if (flash_error_in) begin // [RULE19]
						snd_sts = STS_FLASH_ERR;
						snd_st2 = flash_status_in;
					end else begin
						snd_sts = STS_OK; // [RULE20]
					end
				end
			end
			ST_HALT: begin
				// Silent until reset; the trusted subsystem is no longer believed
				st_d.state = ST_HALT;
			end
			default: begin
				st_d.state = ST_IDLE;
			end
		endcase
		if (go) begin
			st_d.state = ST_SEND;
			st_d.ret = snd_ret;
			st_d.idx = 4'h0;
			st_d.sts = snd_sts;
			st_d.res = (snd_sts == STS_OK) ? RESP_OK : RESP_ERR; // [RULE1] [RULE2]
			st_d.st2 = snd_st2; // [RULE21]
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			st_q <= '{state: ST_IDLE, ret: ST_IDLE, default: '0};
		end else if (ce_in) begin
			st_q <= st_d;
		end
	end

	key_data_mem #(.WIDTH(8), .DEPTH(KEY_DATA_BYTES), .AW(MEM_AW)) u_mem (
		.core_clk_in(core_clk_in),
		.ce_in(ce_in),
		.wr_en_in(mem_we),
		.wr_addr_in(st_q.cnt[MEM_AW-1:0]),
		.wr_data_in(rx_data_in),
		.rd_addr_in(key_rd_addr_in),
		.rd_data_out(key_rd_data_out)
	);

	assign tx_data_out = st_q.tx_data;
	assign tx_valid_out = st_q.tx_valid;
	assign key_type_byte_out = st_q.key_type;
	assign wrap_start_out = st_q.wrap_start;
	assign flash_start_out = st_q.flash_start;
	assign key_store_address_out = st_q.key_addr;
	assign user_key_type_out = st_q.ukey_type;
	assign user_key_cmd_out = st_q.ukey_cmd;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	ok_sum_a: assert property (tx_valid_out && st_q.idx == 4'he && st_q.res == RESP_OK |-> // [RULE1]
		tx_data_out == 8'hd6) else $error("OK status sum byte wrong");
	err_code_a: assert property (tx_valid_out && st_q.idx == 4'h4 && st_q.sts != STS_OK |-> // [RULE2]
		tx_data_out == RESP_ERR) else $error("error status lacks error response code");
	end_byte_a: assert property (tx_valid_out && st_q.idx == STATUS_BYTES |-> // [RULE2]
		tx_data_out == END_BYTE) else $error("status packet end byte wrong");
	wait_soh_a: assert property (ce_in && st_q.state == ST_IDLE && rx_valid_in && // [RULE3]
		rx_data_in != CMD_START_BYTE |=> st_q.state == ST_IDLE) else $error("left idle on stray byte");
	missing_etx_a: assert property (ce_in && st_q.state == ST_CETX && rx_valid_in && // [RULE4]
		rx_data_in != END_BYTE && st_q.cmd == CMD_KEY_SET |=> st_q.state == ST_SEND &&
		st_q.sts == STS_PACKET_ERR) else $error("missing end byte not reported");
	wait_sod_a: assert property (ce_in && st_q.state == ST_DWAIT && rx_valid_in && // [RULE13]
		rx_data_in != DATA_START_BYTE |=> st_q.state == ST_DWAIT) else $error("stray byte taken");
	wrap_pulse_a: assert property (wrap_start_out |=> !wrap_start_out ##1 // [RULE7]
		!wrap_start_out) else $error("wrap start not a single pulse");
	halt_quiet_a: assert property (st_q.state == ST_HALT |=> !tx_valid_out [*3]) // [RULE17]
		else $error("response sent after subsystem fault");
	flash_detail_a: assert property (ce_in && st_q.state == ST_FLASH && flash_done_in && // [RULE19]
		flash_error_in && !trusted_abnormal_in |=> st_q.st2 == $past(flash_status_in) &&
		st_q.sts == STS_FLASH_ERR) else $error("flash status not carried");
endmodule : key_set_cmd

// >>> rtl/key_set_pkg.sv
// Constants for the key setting command handler
package key_set_pkg;
	// Framing bytes
	localparam logic [7:0] CMD_START_BYTE = 8'h01;
	localparam logic [7:0] DATA_START_BYTE = 8'h81;
	localparam logic [7:0] END_BYTE = 8'h03;
	// Command codes and the length each one needs
	localparam logic [7:0] CMD_KEY_SET = 8'h28;
	localparam logic [7:0] CMD_USER_KEY_SET = 8'h2a;
	localparam logic [15:0] KEY_SET_LEN = 16'h0002;
	localparam logic [15:0] USER_KEY_SET_LEN = 16'h0006;
	localparam logic [15:0] CMD_MAX_LEN = 16'h0006;
	// Key types
	localparam logic [7:0] KEY_LEVEL_TWO = 8'h01;
	localparam logic [7:0] KEY_LEVEL_ONE = 8'h02;
	localparam logic [7:0] KEY_RETURN = 8'h03;
	// Authentication levels as presented on auth_level_in
	localparam logic [1:0] AUTH_LEVEL_ONE = 2'h1;
	localparam logic [1:0] AUTH_LEVEL_TWO = 2'h2;
	// Key data packet
	localparam logic [15:0] KEY_DATA_LEN = 16'h0055;
	localparam int KEY_DATA_BYTES = 84;
	// Status packet
	localparam logic [7:0] RESP_OK = 8'h28;
	localparam logic [7:0] RESP_ERR = 8'ha8;
	localparam logic [15:0] STATUS_LEN = 16'h000a;
	localparam logic [31:0] UNUSED_WORD = 32'hffffffff;
	localparam logic [3:0] STATUS_BYTES = 4'hf;
	localparam logic [3:0] STATUS_SUM_IDX = 4'hd;
	// Status codes
	localparam logic [7:0] STS_OK = 8'h00;
	localparam logic [7:0] STS_PACKET_ERR = 8'hc1;
	localparam logic [7:0] STS_CHECKSUM_ERR = 8'hc2;
	localparam logic [7:0] STS_ACCEPT_ERR = 8'hc3;
	localparam logic [7:0] STS_PARAM_ERR = 8'hc5;
	localparam logic [7:0] STS_SECURE_ERR = 8'hd0;
	localparam logic [7:0] STS_TRUSTED_ERR = 8'hd1;
	localparam logic [7:0] STS_FLASH_ERR = 8'he1;

	typedef enum logic [16:0] {
		ST_IDLE = 17'h00001,
		ST_CLEN_H = 17'h00002,
		ST_CLEN_L = 17'h00004,
		ST_CPAY = 17'h00008,
		ST_CSUM = 17'h00010,
		ST_CETX = 17'h00020,
		ST_SEND = 17'h00040,
		ST_DWAIT = 17'h00080,
		ST_DLEN_H = 17'h00100,
		ST_DLEN_L = 17'h00200,
		ST_DRES = 17'h00400,
		ST_DPAY = 17'h00800,
		ST_DSUM = 17'h01000,
		ST_DETX = 17'h02000,
		ST_WRAP = 17'h04000,
		ST_FLASH = 17'h08000,
		ST_HALT = 17'h10000
	} st_e;
endpackage : key_set_pkg

// >>> tb/host_model.sv
// Host programming tool model: sends byte frames and collects status bytes
`timescale 1ns/1ps
module host_model (
	input wire logic core_clk_in,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out
);
	logic slow = 1'b0;
	logic [7:0] resp[$];

	initial begin
		rx_data_out = 8'h00;
		rx_valid_out = 1'b0;
		tx_ready_out = 1'b1;
	end

	// Slow mode drops ready on every other cycle, the block must hold each status byte meanwhile
	always @(posedge core_clk_in) begin
		if (tx_valid_in && tx_ready_out) begin
			resp.push_back(tx_data_in);
		end
		tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bytes go back to back; afterwards the line shows the inverse of the last byte
	task automatic send_raw(input logic [7:0] q[$]);
		foreach (q[i]) begin
			@(posedge core_clk_in);
			rx_data_out <= q[i];
			rx_valid_out <= 1'b1;
		end
		@(posedge core_clk_in);
		rx_valid_out <= 1'b0;
		rx_data_out <= ~q[q.size()-1];
	endtask : send_raw

	// Start byte, body from length high on, sum, end byte; faults only on request
	task automatic send_frame(input logic [7:0] start, input logic [7:0] body[$],
		input logic bad_sum, input logic bad_end);
		logic [7:0] s;
		logic [7:0] q[$];
		s = 8'h00;
		foreach (body[i]) s = s + body[i];
		q = body;
		q.push_front(start);
		q.push_back(8'h00 - s + {7'h00, bad_sum});
		q.push_back(bad_end ? 8'h04 : 8'h03);
		send_raw(q);
	endtask : send_frame
endmodule : host_model

// >>> tb/tb_top.sv
// Self-checking testbench for the key setting command handler
`timescale 1ns/1ps
module tb_top;
	import key_set_pkg::*;
	logic core_clk_in, rst_n_in, ce_in, rx_valid, tx_valid, tx_ready;
	logic [7:0] rx_data, tx_data, kt_out, rd_data, ukt;
	logic forbid, enc_pend, wrap_start, wrap_done, wrap_fail, abnormal, user_cmd;
	logic flash_start, flash_done, flash_err;
	logic [1:0] auth;
	logic [31:0] flash_sts, key_addr;
	logic [6:0] rd_addr;
	logic [7:0] b[$];
	int bad_count = 0;
	int n_tests = 0;
	int wraps = 0;
	int users = 0;

	key_set_cmd dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
		.rx_data_in(rx_data), .rx_valid_in(rx_valid), .tx_data_out(tx_data),
		.tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .lifecycle_forbid_in(forbid),
		.enc_write_pending_in(enc_pend), .auth_level_in(auth), .key_type_byte_out(kt_out),
		.wrap_start_out(wrap_start), .wrap_done_in(wrap_done), .wrap_fail_in(wrap_fail),
		.trusted_abnormal_in(abnormal), .flash_start_out(flash_start),
		.flash_done_in(flash_done), .flash_error_in(flash_err), .flash_status_in(flash_sts),
		.key_rd_addr_in(rd_addr), .key_rd_data_out(rd_data), .key_store_address_out(key_addr),
		.user_key_type_out(ukt), .user_key_cmd_out(user_cmd));
	host_model host (.core_clk_in(core_clk_in), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
		.tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));

	initial begin
		core_clk_in = 1'b0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end

	// Prompt wrap and flash units: done follows start by one cycle
	always @(posedge core_clk_in) begin
		wrap_done <= wrap_start;
		flash_done <= flash_start;
		if (wrap_start) wraps++;
		if (user_cmd) users++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report();
		if (bad_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	function automatic logic [7:0] key_byte(input int i, input logic [7:0] s);
		return 8'(i * 7) + s;
	endfunction : key_byte

	// Status sum is worked out from the listed fields, giving D6h for OK
	task automatic expect_status(input logic [7:0] res, input logic [7:0] sts,
		input logic [31:0] st2);
		logic [7:0] e[$];
		logic [7:0] s;
		int i;
		e = {8'h81, 8'h00, 8'h0a, res, sts, st2[31:24], st2[23:16], st2[15:8], st2[7:0],
			8'hff, 8'hff, 8'hff, 8'hff};
		s = 8'h00;
		for (i = 1; i < 13; i++) s = s + e[i];
		e.push_back(8'h00 - s);
		e.push_back(8'h03);
		i = 0;
		while (host.resp.size() < 15 && i < 600) begin
			@(posedge core_clk_in);
			i++;
		end
		if (i == 600) begin
			bad_count++;
			final_report();
		end
		for (i = 0; i < 15; i++) check("status byte", {24'h0, host.resp[i]}, {24'h0, e[i]});
		host.resp.delete();
		repeat (3) @(posedge core_clk_in);
	endtask : expect_status

	task automatic do_reset();
		rst_n_in <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(posedge core_clk_in);
		check("tx valid after reset", {31'h0, tx_valid}, 32'h0);
	endtask : do_reset

	// Accepted key command, then the key data packet with optional faults
	task automatic cmd_data(input logic [7:0] kt, input logic [15:0] len,
		input logic [7:0] res, input logic bs, input logic be);
		int i;
		b = {8'h00, 8'h02, CMD_KEY_SET, kt};
		host.send_frame(8'h01, b, 1'b0, 1'b0);
		expect_status(RESP_OK, STS_OK, UNUSED_WORD);
		b = {8'h01, 8'h28, 8'h00};
		host.send_raw(b);
		b = {len[15:8], len[7:0], res};
		for (i = 1; i < int'(len); i++) b.push_back(key_byte(i - 1, kt));
		host.send_frame(8'h81, b, bs, be);
	endtask : cmd_data

	task automatic ok_flow(input logic [7:0] kt, input logic [1:0] lvl);
		int w;
		w = wraps;
		auth <= lvl;
		b = {8'h55, 8'h81, 8'h03};
		host.send_raw(b);
		cmd_data(kt, KEY_DATA_LEN, 8'h28, 1'b0, 1'b0);
		expect_status(RESP_OK, STS_OK, UNUSED_WORD);
		check("wrap count", 32'(wraps - w), 32'h1);
		check("key type", {24'h0, kt_out}, {24'h0, kt});
		rd_addr <= 7'h00;
		repeat (2) @(posedge core_clk_in);
		check("key byte first", {24'h0, rd_data}, {24'h0, key_byte(0, kt)});
		rd_addr <= 7'h53;
		repeat (2) @(posedge core_clk_in);
		check("key byte last", {24'h0, rd_data}, {24'h0, key_byte(83, kt)});
	endtask : ok_flow

	task automatic cmd_err(input logic bs, input logic be, input logic [7:0] sts);
		int w;
		w = wraps;
		host.send_frame(8'h01, b, bs, be);
		expect_status(RESP_ERR, sts, UNUSED_WORD);
		check("no wrap", 32'(wraps - w), 32'h0);
	endtask : cmd_err

	task automatic data_err(input logic [15:0] len, input logic [7:0] res, input logic bs,
		input logic be, input logic [7:0] sts);
		int w;
		w = wraps;
		cmd_data(KEY_LEVEL_ONE, len, res, bs, be);
		expect_status(RESP_ERR, sts, UNUSED_WORD);
		check("no wrap", 32'(wraps - w), 32'h0);
	endtask : data_err

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int i;
		int u;
		rst_n_in = 1'b0;
		ce_in = 1'b1;
		forbid = 1'b0;
		enc_pend = 1'b0;
		auth = AUTH_LEVEL_TWO;
		wrap_fail = 1'b0;
		abnormal = 1'b0;
		flash_err = 1'b0;
		flash_sts = 32'h0;
		rd_addr = 7'h00;
		do_reset();
		ok_flow(KEY_LEVEL_TWO, AUTH_LEVEL_TWO);
		host.slow = 1'b1;
		ok_flow(KEY_RETURN, AUTH_LEVEL_TWO);
		host.slow = 1'b0;
		ok_flow(KEY_LEVEL_ONE, AUTH_LEVEL_TWO);
		ok_flow(KEY_LEVEL_ONE, AUTH_LEVEL_ONE);
		b = {8'h00, 8'h02, 8'h28, 8'h02};
		cmd_err(1'b1, 1'b1, STS_PACKET_ERR);
		cmd_err(1'b1, 1'b0, STS_CHECKSUM_ERR);
		b = {8'h00, 8'h00, 8'h28};
		cmd_err(1'b0, 1'b0, STS_PACKET_ERR);
		b = {8'h00, 8'h06, 8'h28, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
		cmd_err(1'b0, 1'b0, STS_PACKET_ERR);
		forbid <= 1'b1;
		b = {8'h00, 8'h02, 8'h28, 8'h05};
		cmd_err(1'b0, 1'b0, STS_ACCEPT_ERR);
		forbid <= 1'b0;
		enc_pend <= 1'b1;
		b = {8'h00, 8'h02, 8'h28, 8'h02};
		cmd_err(1'b0, 1'b0, STS_ACCEPT_ERR);
		enc_pend <= 1'b0;
		for (i = 0; i < 5; i++) begin
			if (i != 2) begin
				b = {8'h00, 8'h02, 8'h28, 8'(i)};
				cmd_err(1'b0, 1'b0, (i == 0 || i == 4) ? STS_PARAM_ERR : STS_SECURE_ERR);
			end
		end
		auth <= 2'h0;
		b = {8'h00, 8'h02, 8'h28, 8'h02};
		cmd_err(1'b0, 1'b0, STS_SECURE_ERR);
		auth <= AUTH_LEVEL_ONE;
		data_err(KEY_DATA_LEN, 8'h28, 1'b1, 1'b1, STS_PACKET_ERR);
		data_err(KEY_DATA_LEN, 8'h28, 1'b1, 1'b0, STS_CHECKSUM_ERR);
		data_err(16'h0054, 8'h28, 1'b0, 1'b0, STS_PACKET_ERR);
		data_err(KEY_DATA_LEN, 8'h29, 1'b0, 1'b0, STS_PACKET_ERR);
		data_err(16'h0056, 8'h28, 1'b0, 1'b0, STS_PARAM_ERR);
		data_err(16'h0056, 8'ha8, 1'b0, 1'b0, STS_PACKET_ERR);
		wrap_fail <= 1'b1;
		cmd_data(KEY_LEVEL_ONE, KEY_DATA_LEN, 8'h28, 1'b0, 1'b0);
		expect_status(RESP_ERR, STS_TRUSTED_ERR, UNUSED_WORD);
		wrap_fail <= 1'b0;
		flash_err <= 1'b1;
		flash_sts <= 32'h5a3c_0f81;
		cmd_data(KEY_LEVEL_ONE, KEY_DATA_LEN, 8'h28, 1'b0, 1'b0);
		expect_status(RESP_ERR, STS_FLASH_ERR, 32'h5a3c_0f81);
		flash_err <= 1'b0;
		b = {8'h00, 8'h06, CMD_USER_KEY_SET, 8'h12, 8'h34, 8'h56, 8'h78, 8'h05};
		u = users;
		host.send_frame(8'h01, b, 1'b0, 1'b0);
		for (i = 0; i < 50 && users == u; i++) @(posedge core_clk_in);
		check("user key pulses", 32'(users - u), 32'h1);
		check("key address", key_addr, 32'h1234_5678);
		check("user key type", {24'h0, ukt}, 32'h5);
		// With the enable low a whole good frame must pass unseen
		ce_in <= 1'b0;
		b = {8'h00, 8'h02, 8'h28, 8'h02};
		host.send_frame(8'h01, b, 1'b0, 1'b0);
		ce_in <= 1'b1;
		repeat (50) @(posedge core_clk_in);
		check("frozen bytes", 32'(host.resp.size()), 32'h0);
		abnormal <= 1'b1;
		cmd_data(KEY_LEVEL_ONE, KEY_DATA_LEN, 8'h28, 1'b0, 1'b0);
		repeat (200) @(posedge core_clk_in);
		check("silent bytes", 32'(host.resp.size()), 32'h0);
		abnormal <= 1'b0;
		do_reset();
		ok_flow(KEY_LEVEL_TWO, AUTH_LEVEL_TWO);
		final_report();
	end
endmodule : tb_top
